// ==== core/spb_pkg.sv ====
// Register map, object layouts and field codes for the sink object builder
package spb_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FIXV = 8'h04;
   localparam logic [7:0] ADDR_VARV = 8'h08;
   localparam logic [7:0] ADDR_BATV = 8'h0c;
   localparam logic [7:0] ADDR_REQV = 8'h10;
   localparam logic [7:0] ADDR_SRCC = 8'h14;
   localparam logic [7:0] ADDR_CMD  = 8'h18;
   localparam logic [7:0] ADDR_STAT = 8'h1c;
   localparam logic [7:0] ADDR_FIXO = 8'h20;
   localparam logic [7:0] ADDR_VARO = 8'h24;
   localparam logic [7:0] ADDR_BATO = 8'h28;
   localparam logic [7:0] ADDR_REQO = 8'h2c;
   // Supply type codes
   localparam logic [1:0] TYPE_FIXED = 2'h0;
   localparam logic [1:0] TYPE_BATT  = 2'h1;
   localparam logic [1:0] TYPE_VAR   = 2'h2;
   // Fast swap current codes
   localparam logic [1:0] FRS_NONE   = 2'h0;
   localparam logic [1:0] FRS_DEFLT  = 2'h1;
   localparam logic [1:0] FRS_1A5    = 2'h2;
   localparam logic [1:0] FRS_3A0    = 2'h3;
   // Command and status bits, and the strap capture wait count
   localparam int CMD_BUILD    = 0;
   localparam int ST_VALID     = 0;
   localparam int ST_POS_ERR   = 1;
   localparam int ST_OP_ERR    = 2;
   localparam int ST_LIM_ERR   = 3;
   localparam int ST_AT_MIN    = 4;
   localparam int ST_CAPS_SEEN = 5;
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   typedef struct packed {
      logic [2:0] obj_pos;
      logic       battery;
      logic       mismatch;
      logic       give_back;
      logic       no_suspend;
      logic       unchunked;
      logic       is_hub;
      logic       dual_role_power;
      logic [1:0] frs_current;
   } spb_ctrl_s;

   typedef struct packed {
      logic [1:0] kind;
      logic       dual_role_power;
      logic       higher_cap;
      logic       ext_powered;
      logic       usb_comm;
      logic       dual_role_data;
      logic [1:0] frs_current;
      logic [2:0] rsvd;
      logic [9:0] volt;
      logic [9:0] current;
   } spb_fixed_obj_s;

   typedef struct packed {
      logic [1:0] kind;
      logic [9:0] volt_max;
      logic [9:0] volt_min;
      logic [9:0] value;
   } spb_range_obj_s;

   typedef struct packed {
      logic       rsvd_top;
      logic [2:0] obj_pos;
      logic       give_back;
      logic       mismatch;
      logic       usb_comm;
      logic       no_suspend;
      logic       unchunked;
      logic [2:0] rsvd;
      logic [9:0] op_value;
      logic [9:0] lim_value;
   } spb_req_obj_s;
endpackage : spb_pkg

// ==== core/spb_builder.sv ====
// Sink capability objects and request object builder with AHB-Lite registers
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Higher-capability flag set while the sink needs more than safe five volts.
// - Externally-powered set for AC supply, or hub whose sources all report it.
// - USB-communications flag follows real data-line capability only.
// - Dual-role-data flag follows swap support, frozen for the device lifetime.
// - Fast-swap current field gives current needed after a completed swap.
// - Fast-swap codes: 0 none (default), 1 default, 2 1.5 A, 3 3.0 A.
// - Variable object: type 10b, max/min voltage 50 mV, current 10 mA.
// - Battery object: type 01b, max/min voltage 50 mV, power 250 mW.
// - Voltage range bounds the supply; value field holds required operating value.
// - Request answers only latest source capabilities, one object, one position.
// - No give-back: position 30..28, operating 19..10, maximum 9..0, 10 mA.
// - Give-back bit 27 set: bits 9..0 hold minimum current instead.
// - Battery, no give-back: operating and maximum power in 250 mW steps.
// - Battery with give-back: minimum power in 9..0, operating unchanged.
// - Bits 26..23: mismatch, USB comm, no suspend, unchunked extended.
// - Bit 31 and bits 22..20 zero; object position never zero.
// - Object position is one-based into the source capability list.
// - Give-back sink drops load to its minimum on go-to-minimum command.
// - Operating value never exceeds the referenced source maximum.
module spb_builder (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        needs_high_voltage,
   input  wire logic        ac_supply_present,
   input  wire logic        upstream_all_ext_powered,
   input  wire logic        usb_data_capable,
   input  wire logic        dual_role_data_strap,
   input  wire logic        go_to_minimum_command,
   output logic [31:0]      power_request_object,
   output logic             request_send,
   output logic [9:0]       load_limit,
   output logic             at_minimum
);
   // Synchroniser bit of each pin input
   localparam int PIN_HIGHV = 0;
   localparam int PIN_AC    = 1;
   localparam int PIN_UPEXT = 2;
   localparam int PIN_USB   = 3;
   localparam int PIN_STRAP = 4;
   localparam int PIN_GTM   = 5;
   localparam int NPIN      = 6;

   spb_pkg::spb_ctrl_s      ctrl_q, ctrl_d;
   logic [19:0]             fixv_q, fixv_d;
   logic [29:0]             varv_q, varv_d;
   logic [29:0]             batv_q, batv_d;
   logic [19:0]             reqv_q, reqv_d;
   logic [12:0]             srcc_q, srcc_d;
   logic                    wr_q, wr_d;
   logic [7:0]              waddr_q, waddr_d;
   logic [31:0]             rdata_q, rdata_d;
   logic [NPIN-1:0]         sync1_q, sync2_q;
   logic [NPIN-1:0]         pin_raw;
   logic                    ready_q, ready_d;
   logic                    resp_q, resp_d;
   logic                    gtm_last_q;
   logic [1:0]              strap_cnt_q, strap_cnt_d;
   logic                    drd_q, drd_d;
   spb_pkg::spb_req_obj_s   req_q, req_d;
   logic                    valid_q, valid_d;
   logic                    send_q, send_d;
   logic [2:0]              err_q, err_d;
   logic [9:0]              limit_q, limit_d;
   logic                    at_min_q, at_min_d;
   logic                    caps_seen_q, caps_seen_d;
   spb_pkg::spb_fixed_obj_s fix_obj;
   spb_pkg::spb_range_obj_s var_obj;
   spb_pkg::spb_range_obj_s bat_obj;
   spb_pkg::spb_req_obj_s   new_req;
   logic                    caps_wr;
   logic                    build;
   logic                    gtm_edge;
   logic                    pos_err;
   logic                    op_err;
   logic                    lim_err;
   logic [9:0]              src_max;
   logic [2:0]              src_count;

   assign src_max   = srcc_q[9:0];
   assign src_count = srcc_q[12:10];
   assign caps_wr   = wr_q && (waddr_q == spb_pkg::ADDR_SRCC);
   assign build     = wr_q && (waddr_q == spb_pkg::ADDR_CMD) && hwdata[spb_pkg::CMD_BUILD];
   // Second stage feeds the edge flop, the strap capture and the object fields
   assign gtm_edge  = sync2_q[PIN_GTM] && !gtm_last_q;

   // Pin order in the synchroniser; all six are async levels
   always_comb begin
      pin_raw            = '0;
      pin_raw[PIN_HIGHV] = needs_high_voltage;
      pin_raw[PIN_AC]    = ac_supply_present;
      pin_raw[PIN_UPEXT] = upstream_all_ext_powered;
      pin_raw[PIN_USB]   = usb_data_capable;
      pin_raw[PIN_STRAP] = dual_role_data_strap;
      pin_raw[PIN_GTM]   = go_to_minimum_command;
   end

   // Capability objects are rebuilt every cycle from live flags
   always_comb begin
      fix_obj                 = '0;
      fix_obj.kind            = spb_pkg::TYPE_FIXED;
      fix_obj.dual_role_power = ctrl_q.dual_role_power;
      fix_obj.higher_cap      = sync2_q[PIN_HIGHV];
      fix_obj.ext_powered     = sync2_q[PIN_AC]
                                || (ctrl_q.is_hub && sync2_q[PIN_UPEXT]);
      fix_obj.usb_comm        = sync2_q[PIN_USB];
      fix_obj.dual_role_data  = drd_q;
      fix_obj.frs_current     = ctrl_q.frs_current;
      fix_obj.volt            = fixv_q[19:10];
      fix_obj.current         = fixv_q[9:0];
      var_obj                 = {spb_pkg::TYPE_VAR, varv_q};
      bat_obj                 = {spb_pkg::TYPE_BATT, batv_q};
   end

   // Request word and its checks against the latest source object
   always_comb begin
      new_req            = '0;
      new_req.obj_pos    = ctrl_q.obj_pos;
      new_req.give_back  = ctrl_q.give_back;
      new_req.mismatch   = ctrl_q.mismatch;
      new_req.usb_comm   = sync2_q[PIN_USB];
      new_req.no_suspend = ctrl_q.no_suspend;
      new_req.unchunked  = ctrl_q.unchunked;
      new_req.op_value   = reqv_q[19:10];
      new_req.lim_value  = reqv_q[9:0];
      pos_err = !caps_seen_q || ctrl_q.obj_pos == 3'h0
                || ctrl_q.obj_pos > src_count;
      op_err  = reqv_q[19:10] > src_max;
      if (ctrl_q.give_back) begin
         lim_err = reqv_q[9:0] >= reqv_q[19:10];
      end else begin
         // A mismatch lets the maximum exceed the offer
         lim_err = reqv_q[19:10] > reqv_q[9:0]
                   || (!ctrl_q.mismatch && reqv_q[9:0] > src_max);
      end
   end

   // Bus and configuration registers
   always_comb begin
      ctrl_d      = ctrl_q;
      fixv_d      = fixv_q;
      varv_d      = varv_q;
      batv_d      = batv_q;
      reqv_d      = reqv_q;
      srcc_d      = srcc_q;
      strap_cnt_d = strap_cnt_q;
      drd_d       = drd_q;
      wr_d        = bus_sel(hsel, hready, htrans) && hwrite;
      waddr_d     = haddr[7:0];
      rdata_d     = rdata_q;
      if (bus_sel(hsel, hready, htrans) && !hwrite) begin
         case (haddr[7:0])
            spb_pkg::ADDR_CTRL: rdata_d = {20'h0, ctrl_q};
            spb_pkg::ADDR_FIXV: rdata_d = {12'h0, fixv_q};
            spb_pkg::ADDR_VARV: rdata_d = {2'h0, varv_q};
            spb_pkg::ADDR_BATV: rdata_d = {2'h0, batv_q};
            spb_pkg::ADDR_REQV: rdata_d = {12'h0, reqv_q};
            spb_pkg::ADDR_SRCC: rdata_d = {19'h0, srcc_q};
            spb_pkg::ADDR_STAT: rdata_d = {26'h0, caps_seen_q, at_min_q, err_q, valid_q};
            spb_pkg::ADDR_FIXO: rdata_d = fix_obj;
            spb_pkg::ADDR_VARO: rdata_d = var_obj;
            spb_pkg::ADDR_BATO: rdata_d = bat_obj;
            spb_pkg::ADDR_REQO: rdata_d = req_q;
            default:            rdata_d = 32'h0;
         endcase
      end
      if (wr_q) begin
         case (waddr_q)
            spb_pkg::ADDR_CTRL: ctrl_d = hwdata[11:0];
            spb_pkg::ADDR_FIXV: fixv_d = hwdata[19:0];
            spb_pkg::ADDR_VARV: varv_d = hwdata[29:0];
            spb_pkg::ADDR_BATV: batv_d = hwdata[29:0];
            spb_pkg::ADDR_REQV: reqv_d = hwdata[19:0];
            spb_pkg::ADDR_SRCC: srcc_d = hwdata[12:0];
            default:            ;
         endcase
      end
      // Strap is taken once, after the synchroniser has filled
      if (strap_cnt_q != spb_pkg::STRAP_WAIT) begin
         strap_cnt_d = strap_cnt_q + 2'h1;
         if (strap_cnt_q == spb_pkg::STRAP_WAIT - 2'h1) begin
            drd_d = dual_role_data_strap_s();
         end
      end
   end

   function automatic logic dual_role_data_strap_s();
      return sync2_q[PIN_STRAP];
   endfunction : dual_role_data_strap_s

   // Address phase qualifier shared by reads and writes
   function automatic logic bus_sel(logic sel, logic rdy, logic [1:0] trans);
      return sel && rdy && trans[1];
   endfunction : bus_sel

   // Request issue and load tracking
   always_comb begin
      req_d       = req_q;
      valid_d     = valid_q;
      send_d      = 1'b0;
      err_d       = err_q;
      limit_d     = limit_q;
      at_min_d    = at_min_q;
      caps_seen_d = caps_seen_q;
      if (caps_wr) begin
         // Older capabilities are stale, the old request no longer answers them
         caps_seen_d = 1'b1;
         valid_d     = 1'b0;
      end else if (build) begin
         err_d = {lim_err, op_err, pos_err};
         if (!pos_err && !op_err && !lim_err) begin
            req_d    = new_req;
            valid_d  = 1'b1;
            send_d   = 1'b1;
            limit_d  = new_req.op_value;
            at_min_d = 1'b0;
         end
      end
      // Command still honoured when new capabilities land in the same cycle
      if (gtm_edge && valid_q && req_q.give_back && !send_d) begin
         limit_d  = req_q.lim_value;
         at_min_d = 1'b1;
      end
   end

   // Zero wait states, always OKAY; flopped so every output is registered
   always_comb begin
      ready_d = 1'b1;
      resp_d  = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q      <= '0;
         fixv_q      <= '0;
         varv_q      <= '0;
         batv_q      <= '0;
         reqv_q      <= '0;
         srcc_q      <= '0;
         wr_q        <= 1'b0;
         waddr_q     <= 8'h00;
         rdata_q     <= 32'h0;
         sync1_q     <= '0;
         sync2_q     <= '0;
         gtm_last_q  <= 1'b0;
         strap_cnt_q <= 2'h0;
         drd_q       <= 1'b0;
         req_q       <= '0;
         valid_q     <= 1'b0;
         send_q      <= 1'b0;
         err_q       <= 3'h0;
         limit_q     <= 10'h000;
         at_min_q    <= 1'b0;
         caps_seen_q <= 1'b0;
         ready_q     <= 1'b1;
         resp_q      <= 1'b0;
      end else begin
         ctrl_q      <= ctrl_d;
         fixv_q      <= fixv_d;
         varv_q      <= varv_d;
         batv_q      <= batv_d;
         reqv_q      <= reqv_d;
         srcc_q      <= srcc_d;
         wr_q        <= wr_d;
         waddr_q     <= waddr_d;
         rdata_q     <= rdata_d;
         // Two-flop synchroniser; only the second stage feeds logic
         sync1_q     <= pin_raw;
         sync2_q     <= sync1_q;
         gtm_last_q  <= sync2_q[PIN_GTM];
         strap_cnt_q <= strap_cnt_d;
         drd_q       <= drd_d;
         req_q       <= req_d;
         valid_q     <= valid_d;
         send_q      <= send_d;
         err_q       <= err_d;
         limit_q     <= limit_d;
         at_min_q    <= at_min_d;
         caps_seen_q <= caps_seen_d;
         ready_q     <= ready_d;
         resp_q      <= resp_d;
      end
   end

   assign hreadyout            = ready_q;
   assign hresp                = resp_q;
   assign hrdata               = rdata_q;
   assign power_request_object = req_q;
   assign request_send         = send_q;
   assign load_limit           = limit_q;
   assign at_minimum           = at_min_q;
endmodule : spb_builder

// ==== test/spb_monitor.sv ====
// Concurrent checks on the request and load outputs of the object builder
`timescale 1ns/1ps
module spb_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        request_send,
   input wire logic [31:0] power_request_object,
   input wire logic [9:0]  load_limit,
   input wire logic        at_minimum,
   input wire logic        go_to_minimum_command
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire [31:0] ro = power_request_object;
   property p_rsvd; request_send |-> ro[31] == 1'b0 && ro[22:20] == 3'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved request bits set");
   property p_pos; request_send |-> ro[30:28] != 3'h0; endproperty
   a_pos: assert property (p_pos) else $error("request position zero");
   property p_pulse; request_send |=> !request_send; endproperty
   a_pulse: assert property (p_pulse) else $error("send pulse too long");
   property p_hold; !request_send |-> $stable(ro); endproperty
   a_hold: assert property (p_hold) else $error("request word changed unsent");
   property p_min; request_send && ro[27] |-> ro[9:0] < ro[19:10]; endproperty
   a_min: assert property (p_min) else $error("minimum not below operating");
   property p_max; request_send && !ro[27] |-> ro[19:10] <= ro[9:0]; endproperty
   a_max: assert property (p_max) else $error("operating above maximum");
   property p_gbk; $rose(at_minimum) |-> ro[27] && load_limit == ro[9:0]; endproperty
   a_gbk: assert property (p_gbk) else $error("load not at minimum");
   property p_cmd; $rose(at_minimum) |-> $past(go_to_minimum_command, 2); endproperty
   a_cmd: assert property (p_cmd) else $error("minimum without command");
endmodule : spb_monitor
bind spb_builder spb_monitor u_mon (
   .hclk(hclk), .hresetn(hresetn), .request_send(request_send),
   .power_request_object(power_request_object), .load_limit(load_limit),
   .at_minimum(at_minimum), .go_to_minimum_command(go_to_minimum_command));

// ==== test/spb_source_model.sv ====
// Source side: collects request words, issues go-to-minimum, judges fast swap
`timescale 1ns/1ps
module spb_source_model #(
   parameter logic [1:0] SWAP_CODE = 2'h2
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        request_send,
   input wire logic [31:0] power_request_object,
   input wire logic [1:0]  frs_needed,
   output logic            go_to_minimum_command,
   output logic            swap_ok,
   output logic [31:0]     last_request,
   output logic [2:0]      sel_index,
   output logic [7:0]      request_count
);
   initial go_to_minimum_command = 1'b0;
   // Decline a swap whose current this source cannot give
   assign swap_ok = frs_needed <= SWAP_CODE;
   assign sel_index = last_request[30:28] - 3'h1;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_request <= 32'h0;
         request_count <= 8'h0;
      end else if (request_send) begin
         last_request <= power_request_object;
         request_count <= request_count + 8'h1;
      end
   end
   task send_go_min;
      go_to_minimum_command <= 1'b1;
      repeat (6) @(posedge hclk);
      go_to_minimum_command <= 1'b0;
   endtask : send_go_min
endmodule : spb_source_model

// ==== test/tb_top.sv ====
// Self-checking bench for the sink object and request builder
`timescale 1ns/1ps
module tb_top;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        nhv = 1'b0, ac = 1'b0, up_ext = 1'b0, usb = 1'b0, strap = 1'b1;
   logic [1:0]  frs_need = 2'h0;
   logic        hreadyout, hresp, request_send, at_minimum, go_min, swap_ok;
   logic [31:0] hrdata, req_obj, last_req, rd;
   logic [9:0]  load_limit;
   logic [7:0]  req_count;
   logic [2:0]  sel_index;
   int          miscompares = 0;
   int          check_count = 0;
   always #25 hclk = ~hclk;
   spb_builder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .needs_high_voltage(nhv),
      .ac_supply_present(ac), .upstream_all_ext_powered(up_ext), .usb_data_capable(usb),
      .dual_role_data_strap(strap), .go_to_minimum_command(go_min),
      .power_request_object(req_obj), .request_send(request_send),
      .load_limit(load_limit), .at_minimum(at_minimum));
   spb_source_model src (.hclk(hclk), .hresetn(hresetn), .request_send(request_send),
      .power_request_object(req_obj), .frs_needed(frs_need), .go_to_minimum_command(go_min),
      .swap_ok(swap_ok), .last_request(last_req), .sel_index(sel_index),
      .request_count(req_count));
   function automatic logic [31:0] ctrl(logic [2:0] pos, logic bat, mm, gb, ns, un, hub,
                                        logic drp, logic [1:0] frs);
      return {20'h0, pos, bat, mm, gb, ns, un, hub, drp, frs};
   endfunction : ctrl
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Master waits on hready in both phases, though this slave never stalls
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rchk
   task automatic build(logic sent, logic [31:0] e);
      logic [7:0] n;
      n = req_count;
      bus(1'b1, spb_pkg::ADDR_CMD, 32'h1);
      repeat (3) @(posedge hclk);
      chk("send count", {24'h0, n + {7'h0, sent}}, {24'h0, req_count});
      if (sent) chk("request", e, req_obj);
   endtask : build
   task automatic t_fixed;
      bus(1'b1, spb_pkg::ADDR_FIXV, {12'h0, 10'd100, 10'd300});
      strap <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         nhv <= i[0];
         ac <= i[1];
         usb <= i[0];
         frs_need <= i[1:0];
         bus(1'b1, spb_pkg::ADDR_CTRL, ctrl(0, 0, 0, 0, 0, 0, 0, i[1], i[1:0]));
         rchk("fixed", spb_pkg::ADDR_FIXO, {2'h0, i[1], i[0], i[1], i[0], 1'b1, i[1:0],
              3'h0, 10'd100, 10'd300});
         chk("swap", {31'h0, i < 3}, {31'h0, swap_ok});
      end
      nhv <= 1'b0;
      ac <= 1'b0;
      usb <= 1'b0;
      up_ext <= 1'b1;
      bus(1'b1, spb_pkg::ADDR_CTRL, ctrl(0, 0, 0, 0, 0, 0, 1, 0, 0));
      rchk("hub", spb_pkg::ADDR_FIXO, {7'h05, 2'h0, 3'h0, 10'd100, 10'd300});
   endtask : t_fixed
   task automatic t_ranges;
      bus(1'b1, spb_pkg::ADDR_VARV, {2'h3, 10'd400, 10'd100, 10'd150});
      rchk("var", spb_pkg::ADDR_VARO, {2'h2, 10'd400, 10'd100, 10'd150});
      bus(1'b1, spb_pkg::ADDR_BATV, {2'h0, 10'd420, 10'd280, 10'd20});
      rchk("bat", spb_pkg::ADDR_BATO, {2'h1, 10'd420, 10'd280, 10'd20});
   endtask : t_ranges
   task automatic t_request;
      usb <= 1'b1;
      bus(1'b1, spb_pkg::ADDR_SRCC, {19'h0, 3'd3, 10'd100});
      bus(1'b1, spb_pkg::ADDR_CTRL, ctrl(2, 0, 0, 0, 1, 1, 0, 0, 0));
      bus(1'b1, spb_pkg::ADDR_REQV, {12'h0, 10'd50, 10'd100});
      build(1'b1, {4'h2, 4'h3, 4'h8, 10'd50, 10'd100});
      chk("index", 32'h1, {29'h0, sel_index});
      rchk("status", spb_pkg::ADDR_STAT, 32'h21);
      bus(1'b1, spb_pkg::ADDR_CTRL, ctrl(2, 0, 1, 0, 0, 0, 0, 0, 0));
      bus(1'b1, spb_pkg::ADDR_REQV, {12'h0, 10'd50, 10'd150});
      build(1'b1, {4'h2, 4'h6, 4'h0, 10'd50, 10'd150});
      bus(1'b1, spb_pkg::ADDR_SRCC, {19'h0, 3'd3, 10'd100});
      rchk("new caps", spb_pkg::ADDR_STAT, 32'h20);
   endtask : t_request
   task automatic t_errors;
      logic [31:0] c[4];
      logic [31:0] q[4];
      logic [31:0] s[4];
      c = '{ctrl(0, 0, 0, 0, 0, 0, 0, 0, 0), ctrl(4, 0, 0, 0, 0, 0, 0, 0, 0),
            ctrl(3, 0, 1, 0, 0, 0, 0, 0, 0), ctrl(1, 0, 0, 1, 0, 0, 0, 0, 0)};
      q = '{{12'h0, 10'd50, 10'd100}, {12'h0, 10'd50, 10'd100},
            {12'h0, 10'd120, 10'd120}, {12'h0, 10'd50, 10'd60}};
      s = '{32'h2, 32'h2, 32'h4, 32'h8};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, spb_pkg::ADDR_CTRL, c[i]);
         bus(1'b1, spb_pkg::ADDR_REQV, q[i]);
         build(1'b0, 32'h0);
         bus(1'b0, spb_pkg::ADDR_STAT, 32'h0);
         chk("error bits", s[i], rd & 32'he);
      end
   endtask : t_errors
   task automatic t_gomin;
      bus(1'b1, spb_pkg::ADDR_CTRL, ctrl(1, 1, 0, 1, 1, 0, 0, 0, 0));
      bus(1'b1, spb_pkg::ADDR_REQV, {12'h0, 10'd40, 10'd10});
      build(1'b1, {4'h1, 4'hb, 4'h0, 10'd40, 10'd10});
      chk("early", 32'h0, {31'h0, at_minimum});
      src.send_go_min();
      repeat (2) @(posedge hclk);
      chk("at minimum", 32'h1, {31'h0, at_minimum});
      chk("load", 32'd10, {22'h0, load_limit});
   endtask : t_gomin
   task stop_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   initial begin
      repeat (4000) @(posedge hclk);
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      t_fixed();
      t_ranges();
      t_request();
      t_errors();
      t_gomin();
      bus(1'b1, 8'h40, 32'hffff_ffff);
      rchk("unmapped", 8'h40, 32'h0);
      stop_test();
   end
endmodule : tb_top
